/* tfs_defines.svh */
// offsets, field positions, reset values and timing counts of the tape block
`ifndef TFS_DEFINES_SVH
`define TFS_DEFINES_SVH
// word bit k of the documented numbering sits at data index 11-k
`define TFS_FN_CODE_HI   11
`define TFS_FN_CODE_LO   9
`define TFS_FN_GAP       8
`define TFS_FN_CHK       7
`define TFS_FN_GO        6
`define TFS_FN_STEP      5
`define TFS_CM_UNIT_HI   11
`define TFS_CM_UNIT_LO   9
`define TFS_CM_PAR       8
`define TFS_CM_IE_ERR    7
`define TFS_CM_IE_DONE   6
`define TFS_CM_FLD_HI    5
`define TFS_CM_FLD_LO    3
`define TFS_CM_DENS_HI   1
`define TFS_CM_DENS_LO   0
`define TFS_DENS_NINE    2'h3
`define TFS_FIELD_TOP    3'h7
`define TFS_ADDR_TOP     12'hfff
`define TFS_WORD_RESET   12'h000
`define TFS_ADDR_RESET   15'h0000
`define TFS_FIFO_DEPTH   16
`define TFS_WORD_W       12
// settling window for the bad-tape check, in ns, and its cycle count
`define TFS_CLK_NS       25
`define TFS_SETTLE_NS    2000
`define TFS_SETTLE_CYC   ((`TFS_SETTLE_NS) / (`TFS_CLK_NS))
`endif

/* tfs_pkg.sv */
// types shared by the tape function and status block
package tfs_pkg;
  typedef enum logic [2:0] {
    TFS_IO_NONE      = 3'b000,
    TFS_IO_LOAD_CNT  = 3'b001,
    TFS_IO_LOAD_ADDR = 3'b010,
    TFS_IO_LOAD_CMD  = 3'b011,
    TFS_IO_LOAD_FUNC = 3'b100,
    TFS_IO_LOAD_BUF  = 3'b101,
    TFS_IO_RD_MAIN   = 3'b110,
    TFS_IO_RD_FUNC   = 3'b111
  } tfs_io_t;
  typedef enum logic [2:0] {
    TFS_FN_OFFLINE = 3'b000,
    TFS_FN_REWIND  = 3'b001,
    TFS_FN_READ    = 3'b010,
    TFS_FN_COMPARE = 3'b011,
    TFS_FN_WRITE   = 3'b100,
    TFS_FN_MARK    = 3'b101,
    TFS_FN_SPC_FWD = 3'b110,
    TFS_FN_SPC_REV = 3'b111
  } tfs_fn_t;
  typedef enum logic [1:0] {
    TFS_ST_IDLE = 2'b00,
    TFS_ST_ARM  = 2'b01,
    TFS_ST_RUN  = 2'b10
  } tfs_state_t;
endpackage : tfs_pkg

/* tfs_core.sv */
// tape function decode, field stepping, data break and status words
`timescale 1ns/1ps
`default_nettype none
`include "tfs_defines.svh"

module tfs_sync #(parameter int W = 1) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_ff <= '0;
      dout    <= '0;
    end else begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end
endmodule : tfs_sync

module tfs_fifo #(parameter int W = 12, parameter int D = 16) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic         ce,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0]   cnt_ff;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;
  assign in_ready  = cnt_ff < (AW+1)'(D);
  assign out_valid = cnt_ff != '0;
  assign out_data  = mem[rd_ff];
  always_ff @(posedge core_clk) begin
    if (ce && push)
      mem[wr_ff] <= in_data;
  end
  always_ff @(posedge core_clk) begin
    if (reset || (ce && flush)) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else if (ce) begin
      if (push)
        wr_ff <= wr_ff + 1'b1;
      if (pop)
        rd_ff <= rd_ff + 1'b1;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : tfs_fifo

module tfs_core (
  // clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // processor i/o instructions
  input  wire logic        io_valid,
  input  wire tfs_pkg::tfs_io_t io_op,
  input  wire logic [11:0] io_wdata,
  output logic      [11:0] io_rdata_ff,
  output logic             io_rvalid_ff,
  // single-cycle data break
  output logic             brk_req_ff,
  output logic             brk_to_mem_ff,
  output logic      [14:0] brk_addr_ff,
  output logic      [11:0] brk_wdata_ff,
  input  wire logic        brk_ack,
  input  wire logic [11:0] brk_rdata,
  output logic             irq_ff,
  // transport levels: ready, rewinding, start, offline, protect, end, nine
  input  wire logic [6:0]  tp_level,
  // transport pulses: word in, word wanted, rec end, mark, lat, lon, missing
  input  wire logic [6:0]  tp_event,
  input  wire logic [11:0] tp_rd_word,
  // transport commands
  output logic             tp_go_ff,
  output tfs_pkg::tfs_fn_t tp_func_ff,
  output logic             tp_long_gap_ff,
  output logic      [2:0]  tp_unit_ff,
  output logic      [1:0]  tp_density_ff,
  output logic             tp_odd_parity_ff,
  output logic      [11:0] tp_wr_word_ff,
  output logic             tp_wr_valid_ff
);
  logic [6:0]  lvl;
  logic [6:0]  evt_s;
  logic [6:0]  evt_d_ff;
  logic [11:0] rdw;
  tfs_sync #(.W(7))  u_lvl (.core_clk(core_clk), .reset(reset),
                            .din(tp_level), .dout(lvl));
  tfs_sync #(.W(7))  u_evt (.core_clk(core_clk), .reset(reset),
                            .din(tp_event), .dout(evt_s));
  tfs_sync #(.W(12)) u_rdw (.core_clk(core_clk), .reset(reset),
                            .din(tp_rd_word), .dout(rdw));
  wire [6:0] evt = evt_s & ~evt_d_ff;
  wire t_ready = lvl[0];
  wire t_rew   = lvl[1];
  wire t_start = lvl[2];
  wire t_off   = lvl[3];
  wire t_prot  = lvl[4];
  wire t_end   = lvl[5];
  wire t_nine  = lvl[6];
  wire e_word  = evt[0];
  wire e_want  = evt[1];
  wire e_rend  = evt[2];
  wire e_mark  = evt[3];
  wire e_lat   = evt[4];
  wire e_lon   = evt[5];
  wire e_miss  = evt[6];

  // registers
  tfs_pkg::tfs_state_t state_ff, nxt_state;
  logic [11:0] function_control_ff;
  logic [11:0] cmd_ff;
  logic [11:0] buf_ff;
  logic [11:0] count_ff;
  logic [14:0] addr_ff;
  logic [11:0] rx_cnt_ff;
  logic        rx_ovf_ff;
  logic [1:0]  rx_cc_ff;
  logic        wc_ovf_ff;
  logic        frozen_ff;
  logic        last_wr_ff;
  logic        err_ff, done_ff, pend_ff, halt_ff;
  logic        par_ff, mark_ff, len_ff, late_ff, cmp_ff, ill_ff;
  logic        bad_ff, f7_ff, lat_ff, lon_ff;
  logic [1:0]  miss_ff;
  logic [6:0]  settle_ff;

  // function decode
  wire tfs_pkg::tfs_fn_t fn = tfs_pkg::tfs_fn_t'(
    function_control_ff[`TFS_FN_CODE_HI:`TFS_FN_CODE_LO]);
  wire is_rd   = fn == tfs_pkg::TFS_FN_READ;
  wire is_cmp  = fn == tfs_pkg::TFS_FN_COMPARE;
  wire is_wr   = fn == tfs_pkg::TFS_FN_WRITE;
  wire is_mark = fn == tfs_pkg::TFS_FN_MARK;
  wire is_sfwd = fn == tfs_pkg::TFS_FN_SPC_FWD;
  wire is_srev = fn == tfs_pkg::TFS_FN_SPC_REV;
  wire is_in   = is_rd || is_cmp;
  wire busy    = state_ff != tfs_pkg::TFS_ST_IDLE;
  wire running = state_ff == tfs_pkg::TFS_ST_RUN;

  // i/o decode
  wire io_cnt  = io_valid && io_op == tfs_pkg::TFS_IO_LOAD_CNT;
  wire io_addr = io_valid && io_op == tfs_pkg::TFS_IO_LOAD_ADDR;
  wire io_cmd  = io_valid && io_op == tfs_pkg::TFS_IO_LOAD_CMD;
  wire io_fn   = io_valid && io_op == tfs_pkg::TFS_IO_LOAD_FUNC;
  wire io_buf  = io_valid && io_op == tfs_pkg::TFS_IO_LOAD_BUF;
  wire io_rdm  = io_valid && io_op == tfs_pkg::TFS_IO_RD_MAIN;
  wire io_rdf  = io_valid && io_op == tfs_pkg::TFS_IO_RD_FUNC;

  // illegal function check on the word being loaded
  wire tfs_pkg::tfs_fn_t new_fn = tfs_pkg::tfs_fn_t'(
    io_wdata[`TFS_FN_CODE_HI:`TFS_FN_CODE_LO]);
  wire new_go   = io_wdata[`TFS_FN_GO];
  wire new_in   = new_fn == tfs_pkg::TFS_FN_READ ||
                  new_fn == tfs_pkg::TFS_FN_COMPARE ||
                  new_fn == tfs_pkg::TFS_FN_SPC_FWD;
  wire new_wr   = new_fn == tfs_pkg::TFS_FN_WRITE ||
                  new_fn == tfs_pkg::TFS_FN_MARK;
  wire bad_dens = t_nine &&
    cmd_ff[`TFS_CM_DENS_HI:`TFS_CM_DENS_LO] != `TFS_DENS_NINE;
  wire ill_busy = busy && (io_cmd || io_fn || io_buf);
  wire ill_fn   = io_fn && !busy && new_go &&
                  (bad_dens ||
                   (new_fn == tfs_pkg::TFS_FN_SPC_REV && t_start) ||
                   (new_in && last_wr_ff) ||
                   !t_ready ||
                   (new_wr && t_prot));
  wire ill_now  = ill_busy || ill_fn;
  wire start    = io_fn && !busy && new_go && !ill_fn;

  // address stepping over the 15-bit field and address counter
  wire        step_en = function_control_ff[`TFS_FN_STEP];
  wire [2:0]  fld     = addr_ff[14:12];
  wire        at_top  = addr_ff[11:0] == `TFS_ADDR_TOP;
  wire        f7_wrap = step_en && at_top && fld == `TFS_FIELD_TOP;
  wire [14:0] addr_up = (step_en && !f7_wrap) ? addr_ff + 15'h0001
                      : {fld, addr_ff[11:0] + 12'h001};

  // fifo between transport and data break
  logic        fi_valid, fi_ready, fo_valid, fo_ready;
  logic [11:0] fi_data, fo_data;
  wire rx_take   = running && is_in && e_word;
  wire rx_keep   = !rx_ovf_ff || rx_cc_ff != 2'h0;
  wire brk_done  = brk_req_ff && brk_ack;
  assign fi_valid = is_in ? (rx_take && rx_keep) : (brk_done && is_wr);
  assign fi_data  = is_in ? rdw : brk_rdata;
  wire tx_take   = running && is_wr && e_want;
  assign fo_ready = is_in ? brk_done : (tx_take && fo_valid);
  tfs_fifo #(.W(`TFS_WORD_W), .D(`TFS_FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk), .reset(reset), .ce(ce), .flush(start),
    .in_valid(fi_valid), .in_ready(fi_ready), .in_data(fi_data),
    .out_valid(fo_valid), .out_ready(fo_ready), .out_data(fo_data));

  // data break launch
  wire brk_go = running && !halt_ff && !brk_req_ff &&
                (is_in ? fo_valid : (is_wr && !wc_ovf_ff && fi_ready));
  wire mism   = brk_done && is_cmp && brk_rdata != fo_data;
  wire wc_inc = brk_done || (running && (is_sfwd || is_srev) && e_rend);
  wire wc_wrap = wc_inc && count_ff == `TFS_ADDR_TOP;

  // error events, deferred until job done
  wire late_ev = (rx_take && rx_keep && !fi_ready) ||
                 (tx_take && !fo_valid);
  wire short_ev = running && is_in && e_rend && !rx_ovf_ff;
  wire long_ev  = rx_take && !rx_keep;
  wire bad_ev   = rx_take && miss_ff == 2'h2 && settle_ff != 7'h00 &&
                  !rx_ovf_ff;
  wire f7_ev    = brk_go && f7_wrap;
  wire space_stop = e_mark || t_start || t_end || wc_wrap || wc_ovf_ff;
  wire job_end  = running && e_rend &&
                  ((is_in || is_wr || is_mark) ||
                   ((is_sfwd || is_srev) && space_stop));
  wire any_err  = mism || late_ev || short_ev || long_ev || bad_ev || f7_ev ||
                  e_lat || e_lon || (is_sfwd && t_end) || t_start;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      tfs_pkg::TFS_ST_IDLE: if (start) nxt_state = tfs_pkg::TFS_ST_ARM;
      tfs_pkg::TFS_ST_ARM:  if (ill_now) nxt_state = tfs_pkg::TFS_ST_IDLE;
                            else if (t_ready) nxt_state = tfs_pkg::TFS_ST_RUN;
      tfs_pkg::TFS_ST_RUN:  if (job_end || ill_now)
                              nxt_state = tfs_pkg::TFS_ST_IDLE;
      default:              nxt_state = tfs_pkg::TFS_ST_IDLE;
    endcase
  end

  // status words
  wire [11:0] main_word = {err_ff, t_rew, t_start, t_off, par_ff,
                           mark_ff, len_ff, late_ff, t_end,
                           t_prot, cmp_ff, ill_ff};
  wire [11:0] func_word = {function_control_ff[11:6], t_nine,
                           bad_ff, f7_ff, lat_ff, 1'b0, lon_ff};

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_ff <= tfs_pkg::TFS_ST_IDLE;
      evt_d_ff <= 7'h00;
      function_control_ff <= `TFS_WORD_RESET;
      cmd_ff   <= `TFS_WORD_RESET;
      buf_ff   <= `TFS_WORD_RESET;
    end else if (ce) begin
      state_ff <= nxt_state;
      evt_d_ff <= evt_s;
      if (io_fn && !busy)
        function_control_ff <= io_wdata;
      if (io_cmd && !busy)
        cmd_ff <= io_wdata;
      if (io_buf && !busy)
        buf_ff <= io_wdata;
    end
  end

  // counters
  always_ff @(posedge core_clk) begin
    if (reset) begin
      count_ff  <= `TFS_WORD_RESET;
      addr_ff   <= `TFS_ADDR_RESET;
      rx_cnt_ff <= `TFS_WORD_RESET;
      rx_ovf_ff <= 1'b0;
      rx_cc_ff  <= 2'h0;
      wc_ovf_ff <= 1'b0;
      frozen_ff <= 1'b0;
    end else if (ce) begin
      if (io_cnt && !busy)
        count_ff <= io_wdata;
      else if (wc_inc)
        count_ff <= count_ff + 12'h001;
      if (io_addr && !busy)
        addr_ff[11:0] <= io_wdata;
      else if (io_cmd && !busy)
        addr_ff[14:12] <= io_wdata[`TFS_CM_FLD_HI:`TFS_CM_FLD_LO];
      else if (brk_go && !frozen_ff)
        addr_ff <= addr_up;
      frozen_ff <= start ? 1'b0 : (frozen_ff || mism);
      wc_ovf_ff <= start ? 1'b0 : (wc_ovf_ff || wc_wrap);
      if (start) begin
        rx_cnt_ff <= count_ff;
        rx_ovf_ff <= 1'b0;
        rx_cc_ff  <= !io_wdata[`TFS_FN_CHK] ? 2'h0 :
                     (t_nine ? 2'h2 : 2'h1);
      end else if (rx_take) begin
        if (!rx_ovf_ff) begin
          rx_cnt_ff <= rx_cnt_ff + 12'h001;
          rx_ovf_ff <= rx_cnt_ff == `TFS_ADDR_TOP;
        end else if (rx_cc_ff != 2'h0)
          rx_cc_ff <= rx_cc_ff - 2'h1;
      end
    end
  end

  // bad tape window: missing-character run and settle countdown
  always_ff @(posedge core_clk) begin
    if (reset) begin
      miss_ff   <= 2'h0;
      settle_ff <= 7'h00;
    end else if (ce) begin
      if (e_miss) begin
        miss_ff   <= (miss_ff == 2'h2) ? miss_ff : miss_ff + 2'h1;
        settle_ff <= 7'(`TFS_SETTLE_CYC);
      end else begin
        if (rx_take)
          miss_ff <= 2'h0;
        if (settle_ff != 7'h00)
          settle_ff <= settle_ff - 7'h01;
      end
    end
  end

  // flags: a set in the same cycle as a clear wins
  always_ff @(posedge core_clk) begin
    if (reset) begin
      {err_ff, done_ff, pend_ff, halt_ff, last_wr_ff} <= 5'h00;
      {par_ff, mark_ff, len_ff, late_ff, cmp_ff, ill_ff} <= 6'h00;
      {bad_ff, f7_ff, lat_ff, lon_ff} <= 4'h0;
    end else if (ce) begin
      pend_ff <= (pend_ff && !start) || any_err;
      err_ff  <= (err_ff && !start) || ill_now ||
                 (job_end && (pend_ff || any_err));
      halt_ff <= (halt_ff && !start) || ill_now;
      done_ff <= (done_ff && !start) || job_end;
      if (start)
        last_wr_ff <= new_wr;
      ill_ff  <= (ill_ff  && !start) || ill_now;
      cmp_ff  <= (cmp_ff  && !start) || mism;
      late_ff <= (late_ff && !start) || late_ev;
      len_ff  <= (len_ff  && !start) || short_ev || long_ev;
      mark_ff <= (mark_ff && !start) ||
                 (running && e_mark && (is_in || is_sfwd || is_srev));
      lat_ff  <= (lat_ff  && !start) || (running && e_lat);
      lon_ff  <= (lon_ff  && !start) || (running && e_lon);
      par_ff  <= (par_ff  && !start) || (running && (e_lat || e_lon));
      f7_ff   <= (f7_ff   && !start) || f7_ev;
      bad_ff  <= (bad_ff  && !start) || bad_ev;
    end
  end

  // data break and transport outputs
  always_ff @(posedge core_clk) begin
    if (reset) begin
      brk_req_ff    <= 1'b0;
      brk_to_mem_ff <= 1'b0;
      brk_addr_ff   <= `TFS_ADDR_RESET;
      brk_wdata_ff  <= `TFS_WORD_RESET;
      tp_wr_word_ff <= `TFS_WORD_RESET;
      tp_wr_valid_ff <= 1'b0;
    end else if (ce) begin
      if (brk_go) begin
        brk_req_ff    <= 1'b1;
        brk_to_mem_ff <= is_rd;
        brk_addr_ff   <= frozen_ff ? addr_ff : addr_up;
        brk_wdata_ff  <= fo_data;
      end else if (brk_done || halt_ff || ill_now)
        brk_req_ff <= 1'b0;
      tp_wr_valid_ff <= tx_take && fo_valid;
      if (tx_take && fo_valid)
        tp_wr_word_ff <= fo_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tp_go_ff         <= 1'b0;
      tp_func_ff       <= tfs_pkg::TFS_FN_OFFLINE;
      tp_long_gap_ff   <= 1'b0;
      tp_unit_ff       <= 3'h0;
      tp_density_ff    <= 2'h0;
      tp_odd_parity_ff <= 1'b0;
      io_rdata_ff      <= `TFS_WORD_RESET;
      io_rvalid_ff     <= 1'b0;
      irq_ff           <= 1'b0;
    end else if (ce) begin
      tp_go_ff <= state_ff == tfs_pkg::TFS_ST_ARM && t_ready &&
                  !ill_now;
      tp_func_ff       <= fn;
      tp_long_gap_ff   <= function_control_ff[`TFS_FN_GAP];
      tp_unit_ff       <= cmd_ff[`TFS_CM_UNIT_HI:`TFS_CM_UNIT_LO];
      tp_density_ff    <= cmd_ff[`TFS_CM_DENS_HI:`TFS_CM_DENS_LO];
      tp_odd_parity_ff <= cmd_ff[`TFS_CM_PAR];
      io_rvalid_ff     <= io_rdm || io_rdf;
      io_rdata_ff      <= io_rdm ? main_word :
                          (io_rdf ? func_word : `TFS_WORD_RESET);
      irq_ff <= (err_ff && cmd_ff[`TFS_CM_IE_ERR]) ||
                (done_ff && cmd_ff[`TFS_CM_IE_DONE]);
    end
  end
endmodule : tfs_core
`default_nettype wire

/* tfs_core_properties.sv */
// port assertions for the tape function and status block
`timescale 1ns/1ps
`default_nettype none
module tfs_core_chk (
  // clock, reset, enable
  input wire logic             core_clk,
  input wire logic             reset,
  input wire logic             ce,
  // i/o and data break
  input wire logic             io_valid,
  input wire tfs_pkg::tfs_io_t io_op,
  input wire logic      [11:0] io_rdata_ff,
  input wire logic             io_rvalid_ff,
  input wire logic             brk_req_ff,
  input wire logic      [14:0] brk_addr_ff,
  input wire logic      [11:0] brk_wdata_ff,
  input wire logic             brk_ack,
  // transport
  input wire logic             tp_go_ff,
  input wire tfs_pkg::tfs_fn_t tp_func_ff,
  input wire logic             tp_wr_valid_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire logic is_rd = io_valid && ce && io_op[2:1] == 2'h3;
  wire logic is_ld = io_valid && ce && io_op != tfs_pkg::TFS_IO_NONE && !is_rd;
  wire logic is_ctl = is_ld && io_op >= tfs_pkg::TFS_IO_LOAD_CMD;
  logic [11:0] last_ff;
  logic        seen_ff;
  // last serviced break address, forgotten at each start
  always_ff @(posedge core_clk) begin
    seen_ff <= !(reset || tp_go_ff) && (seen_ff || (brk_ack && brk_req_ff));
    if (brk_ack && brk_req_ff)
      last_ff <= brk_addr_ff[11:0];
  end
  AST_RD_ANSWER: assert property (is_rd |=> io_rvalid_ff)
    else $error("status read not answered");
  AST_LOAD_SILENT: assert property (is_ld |=> !io_rvalid_ff)
    else $error("load answered like a read");
  AST_RD_IDLE: assert property (
    !io_rvalid_ff |-> io_rdata_ff == 12'h000)
    else $error("read data not zero outside answer");
  AST_GO_PULSE: assert property (tp_go_ff |=> !tp_go_ff)
    else $error("start pulse longer than one cycle");
  AST_BRK_HOLD: assert property (
    brk_req_ff && !brk_ack && !is_ctl |=>
    brk_req_ff && $stable(brk_addr_ff) && $stable(brk_wdata_ff))
    else $error("break request changed before ack");
  AST_BRK_DROP: assert property (
    brk_ack && brk_req_ff |=> !brk_req_ff)
    else $error("break request held after ack");
  AST_ADDR_STEP: assert property ($rose(brk_req_ff) && seen_ff &&
    tp_func_ff != tfs_pkg::TFS_FN_COMPARE |->
    brk_addr_ff[11:0] == last_ff + 12'h001)
    else $error("break address did not step by one");
  AST_WR_PULSE: assert property (tp_wr_valid_ff |=> !tp_wr_valid_ff)
    else $error("write word valid longer than one cycle");
endmodule : tfs_core_chk
bind tfs_core tfs_core_chk u_chk (.core_clk, .reset, .ce, .io_valid, .io_op,
  .io_rdata_ff, .io_rvalid_ff, .brk_req_ff, .brk_addr_ff, .brk_wdata_ff,
  .brk_ack, .tp_go_ff, .tp_func_ff, .tp_wr_valid_ff);
`default_nettype wire

/* tfs_tape_model.sv */
// behavioural tape transport answering start pulses
`timescale 1ns/1ps
`default_nettype none
module tfs_tape_model #(parameter int NWORDS = 2) (
  // clock and commands
  input  wire logic             core_clk,
  input  wire logic             tp_go_ff,
  input  wire tfs_pkg::tfs_fn_t tp_func_ff,
  // bench set-up
  input  wire logic             rdy,
  input  wire logic             prot,
  // transport lines
  output logic      [6:0]       tp_level,
  output logic      [6:0]       tp_event,
  output logic      [11:0]      tp_rd_word
);
  assign tp_level = {2'h0, prot, 3'h0, rdy};
  task automatic pulse(input int b);
    repeat (4) @(negedge core_clk);
    tp_event[b] = 1'b1;
    repeat (4) @(negedge core_clk);
    tp_event[b] = 1'b0;
  endtask : pulse
  task automatic job(input tfs_pkg::tfs_fn_t fn);
    for (int i = 1; i <= NWORDS; i++) begin
      if (fn == tfs_pkg::TFS_FN_READ || fn == tfs_pkg::TFS_FN_COMPARE) begin
        tp_rd_word = 12'h5a0 + 12'(i);
        pulse(0);
        tp_rd_word = ~tp_rd_word;
      end else if (fn == tfs_pkg::TFS_FN_WRITE) begin
        pulse(1);
      end
    end
    pulse(2); // record end closes the block
  endtask : job
  initial begin
    tp_event = 7'h00;
    tp_rd_word = 12'h000;
    forever begin
      @(posedge core_clk);
      if (tp_go_ff === 1'b1)
        job(tp_func_ff);
    end
  end
endmodule : tfs_tape_model
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the tape function and status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic             core_clk = 1'b0, reset = 1'b1, io_valid = 1'b0;
  tfs_pkg::tfs_io_t io_op = tfs_pkg::TFS_IO_NONE;
  logic      [11:0] io_wdata = 12'h000, brk_rdata = 12'h000, rd;
  logic             brk_ack = 1'b0, rdy = 1'b1, prot = 1'b0;
  logic             io_rvalid_ff, brk_req_ff, brk_to_mem_ff, irq_ff;
  logic             tp_go_ff, tp_wr_valid_ff;
  logic      [11:0] io_rdata_ff, brk_wdata_ff, tp_rd_word, tp_wr_word_ff;
  logic      [14:0] brk_addr_ff;
  logic       [6:0] tp_level, tp_event;
  tfs_pkg::tfs_fn_t tp_func_ff;
  logic      [11:0] mem [0:32767];
  logic      [11:0] wrq [$];
  int               failures = 0, num_checks = 0, gos = 0;
  tfs_core u_dut (.core_clk, .reset, .ce(1'b1), .io_valid, .io_op, .io_wdata,
    .io_rdata_ff, .io_rvalid_ff, .brk_req_ff, .brk_to_mem_ff, .brk_addr_ff,
    .brk_wdata_ff, .brk_ack, .brk_rdata, .irq_ff, .tp_level, .tp_event,
    .tp_rd_word, .tp_go_ff, .tp_func_ff, .tp_long_gap_ff(), .tp_unit_ff(),
    .tp_density_ff(), .tp_odd_parity_ff(), .tp_wr_word_ff, .tp_wr_valid_ff);
  tfs_tape_model u_tape (.core_clk, .tp_go_ff, .tp_func_ff, .rdy, .prot,
    .tp_level, .tp_event, .tp_rd_word);
  always #12.5 core_clk = ~core_clk;
  // memory side of the data break, one ack per request
  always @(negedge core_clk) begin
    brk_ack = brk_req_ff === 1'b1 && !brk_ack;
    if (brk_ack) begin
      brk_rdata = mem[brk_addr_ff];
      if (brk_to_mem_ff)
        mem[brk_addr_ff] = brk_wdata_ff;
    end
  end
  always @(posedge core_clk) begin
    if (tp_go_ff === 1'b1)
      gos++;
    if (tp_wr_valid_ff === 1'b1)
      wrq.push_back(tp_wr_word_ff);
  end
  task automatic chk(input logic [11:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s: got %h, expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic io(input tfs_pkg::tfs_io_t op, input logic [11:0] wd);
    @(negedge core_clk);
    io_valid = 1'b1;
    io_op = op;
    io_wdata = wd;
    @(negedge core_clk);
    io_valid = 1'b0;
    for (int i = 0; i < 3 && io_rvalid_ff !== 1'b1; i++) @(negedge core_clk);
    rd = io_rdata_ff;
  endtask : io
  task automatic start(input logic [11:0] adr, cmd, fn);
    io(tfs_pkg::TFS_IO_LOAD_CNT, 12'hffe);
    io(tfs_pkg::TFS_IO_LOAD_ADDR, adr);
    io(tfs_pkg::TFS_IO_LOAD_CMD, cmd);
    io(tfs_pkg::TFS_IO_LOAD_FUNC, fn);
    repeat (6) @(negedge core_clk);
    for (int n = 0; n < 500 && irq_ff !== 1'b1; n++) @(negedge core_clk);
  endtask : start
  task automatic t_read(input logic [2:0] fld, input logic step);
    logic [2:0] nf;
    logic       f7;
    f7 = step && fld == 3'h7;
    nf = (step && !f7) ? fld + 3'h1 : fld;
    start(12'hfff, {6'h01, fld, 3'h0}, {6'h11, step, 5'h00});
    chk(mem[{nf, 12'h000}], 12'h5a1, "first word");
    chk(mem[{nf, 12'h001}], 12'h5a2, "second word");
    io(tfs_pkg::TFS_IO_RD_MAIN, 12'h000);
    chk(rd, {f7, 11'h000}, "main status after read");
    io(tfs_pkg::TFS_IO_RD_FUNC, 12'h000);
    chk(rd, {6'h11, 2'h0, f7, 3'h0}, "function word");
  endtask : t_read
  task automatic t_compare;
    mem[15'h0200] = 12'h5a1;
    mem[15'h0201] = 12'h000;
    start(12'h1ff, 12'h040, 12'h640);
    io(tfs_pkg::TFS_IO_RD_MAIN, 12'h000);
    chk(rd, 12'h802, "main status after compare");
  endtask : t_compare
  task automatic t_write;
    mem[15'h0100] = 12'h3c1;
    mem[15'h0101] = 12'h3c2;
    wrq.delete();
    start(12'h0ff, 12'h040, 12'h840);
    chk(12'(wrq.size()), 12'h002, "words written");
    chk(wrq[0], 12'h3c1, "written word 0");
    chk(wrq[1], 12'h3c2, "written word 1");
  endtask : t_write
  task automatic t_illegal(input logic r, p, input logic [11:0] fw);
    int g;
    // a legal write job clears the flags left by an earlier case
    t_write();
    g = gos;
    rdy = r;
    prot = p;
    repeat (4) @(negedge core_clk);
    io(tfs_pkg::TFS_IO_RD_MAIN, 12'h000);
    chk(12'({rd[11], rd[2], rd[0]}), 12'({p, 1'b0}), "flags");
    io(tfs_pkg::TFS_IO_LOAD_FUNC, fw);
    repeat (8) @(negedge core_clk);
    io(tfs_pkg::TFS_IO_RD_MAIN, 12'h000);
    chk({10'h0, rd[11], rd[0]}, 12'h003, "illegal and error flags");
    chk(12'(gos - g), 12'h000, "start withheld");
    rdy = 1'b1;
    prot = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask : t_illegal
  task automatic test_done;
    $display("checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  initial begin
    #500000;
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end
  initial begin
    repeat (4) @(negedge core_clk);
    reset = 1'b0;
    repeat (3) @(negedge core_clk);
    io(tfs_pkg::TFS_IO_RD_MAIN, 12'h000);
    chk(rd, 12'h000, "main status after reset");
    t_read(3'h2, 1'b0);
    t_read(3'h2, 1'b1);
    t_read(3'h7, 1'b1);
    t_compare();
    t_write();
    t_illegal(1'b1, 1'b0, 12'h440);
    t_illegal(1'b1, 1'b1, 12'h840);
    t_illegal(1'b0, 1'b0, 12'h840);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
